//--- src/sswr_ctrl_end.sv
/*
 * Controller end: samples the shared reset and interrupt lines through
 * synchronisers, may pull reset low on request, and writes the supply-on
 * acknowledge as a registered strobe that lasts as long as the user write. Assumes one common clock.
 */
`timescale 1ns/100ps
module sswr_ctrl_end
    import sswr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    sswr_link_if.ctrl link,
    input wire logic user_reset_request,
    input wire logic user_ack_write,
    output logic in_reset,
    output logic irq_pending,
    output logic ack_done
);
    logic [SYNC_STAGES-1:0] rst_sync;
    logic [SYNC_STAGES-1:0] irq_sync;
    logic ctrl_reset_oe;
    logic ack_strobe;
    logic next_ctrl_reset_oe;
    logic next_ack_strobe;
    logic next_ack_done;

    // Drive only low or release
    always_comb
    begin
        next_ctrl_reset_oe = user_reset_request; // R07
        next_ack_strobe = user_ack_write && !in_reset; // R01
        next_ack_done = ack_done;
        if (in_reset)
        begin
            next_ack_done = 1'b0;
        end
        else if (ack_strobe)
        begin
            next_ack_done = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rst_sync <= '0;
            irq_sync <= '1;
            ctrl_reset_oe <= 1'b0;
            ack_strobe <= 1'b0;
            ack_done <= 1'b0;
            in_reset <= 1'b1;
            irq_pending <= 1'b0;
        end
        else
        begin
            // Reset and interrupt lines taken through the two-stage synchronisers
            rst_sync <= {rst_sync[0], link.reset_line};
            irq_sync <= {irq_sync[0], link.irq_line}; // R09
            ctrl_reset_oe <= next_ctrl_reset_oe;
            ack_strobe <= next_ack_strobe;
            ack_done <= next_ack_done;
            in_reset <= ~rst_sync[1]; // R06
            irq_pending <= ~irq_sync[1]; // R08
        end
    end

    assign link.ctrl_reset_oe = ctrl_reset_oe;
    assign link.supply_on_ack_bit = ack_strobe;
endmodule : sswr_ctrl_end

//--- src/sswr_die_end.sv
/*
 * Analog die end: power-up reset hold, startup acknowledge timeout into
 * sleep, wake detection on the wake input and bus, and the open-drain
 * reset and interrupt drivers. Assumes pins synchronous to the clock
 * except the test-mode pin, which is synchronised here.
 */
`timescale 1ns/100ps
// Contract
// R01: Acknowledge within 80 ms else sleep
// R02: Test mode disables timeout and receiver
// R03: Test pin high selects test mode
// R04: Both wake input edges wake system
// R05: Internal reset sources pull reset low
// R06: Low reset line restarts controller
// R07: Reset line open drain, low or release
// R08: Interrupt low for errors and wakes
// R09: Controller takes interrupt asynchronously; the code passes it through a two-stage synchroniser
// R10: Stop mode wakes gated by masks
// R11: Sleep wakes unmaskable, act as power-on
// R12: Hold reset 1.25 ms after supply rise
// R13: Bus wake reported two cycles later
// R14: Timeout restarts on reset, stops on ack
// R15: Test pin synchronised before use
module sswr_die_end
    import sswr_pkg::*;
#(
    parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
    parameter int TIMEOUT_CYCLES = ACK_TIMEOUT_CYCLES
)
(
    input wire logic clock,
    input wire logic reset,
    sswr_link_if.die link,
    input wire logic test_mode_pin,
    input wire logic wake_input,
    input wire logic bus_rx,
    input wire logic internal_reset_src,
    input wire logic error_event,
    input wire logic [1:0] mode_select,
    input wire logic bus_wake_mask,
    input wire logic wake_input_mask,
    input wire logic irq_clear,
    output logic sleep_active,
    output logic receiver_enable,
    output logic wake_flag_input,
    output logic wake_flag_bus
);
    logic [SYNC_STAGES-1:0] test_sync;
    logic test_mode;
    logic wake_prev;
    logic bus_prev;
    logic [BUS_WAKE_DELAY-1:0] bus_pipe;
    sswr_state_t state;
    sswr_state_t next_state;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic reset_oe;
    logic next_reset_oe;
    logic irq_oe;
    logic next_irq_oe;
    logic next_wake_flag_input;
    logic next_wake_flag_bus;
    logic wake_edge;
    logic bus_edge;
    logic bus_wake;
    logic gated_wake;
    logic line_low;
    logic [SYNC_STAGES-1:0] next_test_sync;
    logic next_wake_prev;
    logic next_bus_prev;
    logic [BUS_WAKE_DELAY-1:0] next_bus_pipe;
    logic next_receiver_enable;
    logic next_sleep_active;

    assign test_mode = test_sync[1]; // R15 R03
    assign wake_edge = wake_input ^ wake_prev; // R04
    assign bus_edge = bus_rx && !bus_prev && receiver_enable;
    assign bus_wake = bus_pipe[BUS_WAKE_DELAY-1]; // R13
    assign line_low = !link.reset_line;
    // Stop mode masks; elsewhere wakes always reach the controller
    assign gated_wake = (mode_select == SSWR_MODE_STOP) ?
        ((wake_edge && wake_input_mask) || (bus_wake && bus_wake_mask)) : // R10
        (wake_edge || bus_wake);

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_reset_oe = 1'b0;
        next_wake_flag_input = wake_flag_input;
        next_wake_flag_bus = bus_wake | wake_flag_bus;
        if (wake_edge)
        begin
            next_wake_flag_input = 1'b1;
        end
        unique case (state)
            SSWR_HOLD:
            begin
                next_reset_oe = 1'b1; // R12
                if (count >= COUNT_W'(HOLD_CYCLES))
                begin
                    next_state = SSWR_WAIT_ACK;
                    next_count = '0;
                end
                else
                begin
                    next_count = count + COUNT_ONE;
                end
            end
            SSWR_WAIT_ACK:
            begin
                if (link.supply_on_ack_bit)
                begin
                    next_state = SSWR_NORMAL; // R14
                end
                else if (!test_mode && count >= COUNT_W'(TIMEOUT_CYCLES))
                begin
                    next_state = SSWR_SLEEP; // R01 R02
                end
                else if (!test_mode)
                begin
                    next_count = count + COUNT_ONE;
                end
            end
            SSWR_NORMAL:
            begin
                if (mode_select == SSWR_MODE_SLEEP)
                begin
                    next_state = SSWR_SLEEP;
                end
            end
            SSWR_SLEEP:
            begin
                next_reset_oe = 1'b1;
                if (wake_edge || bus_wake)
                begin
                    next_state = SSWR_HOLD; // R11
                    next_count = '0;
                end
            end
        endcase
        // Internal source or reset seen on the line restarts the timeout
        if (internal_reset_src || (line_low && !reset_oe && state != SSWR_SLEEP))
        begin
            next_reset_oe = internal_reset_src; // R05 R06
            next_state = SSWR_WAIT_ACK; // R14
            next_count = '0;
        end
        // Set wins over clear
        next_irq_oe = gated_wake || error_event || (irq_oe && !irq_clear); // R08
        if (irq_clear)
        begin
            next_wake_flag_input = wake_edge;
            next_wake_flag_bus = bus_wake;
        end
        next_sleep_active = (next_state == SSWR_SLEEP);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state <= SSWR_HOLD;
            count <= '0;
            reset_oe <= 1'b1;
            irq_oe <= 1'b0;
            wake_flag_input <= 1'b0;
            wake_flag_bus <= 1'b0;
            sleep_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            reset_oe <= next_reset_oe;
            irq_oe <= next_irq_oe;
            wake_flag_input <= next_wake_flag_input;
            wake_flag_bus <= next_wake_flag_bus;
            sleep_active <= next_sleep_active;
        end
    end

    // Pin sampling: synchroniser, edge history and bus wake pipeline
    always_comb
    begin
        next_test_sync = {test_sync[0], test_mode_pin};
        next_wake_prev = wake_input;
        next_bus_prev = bus_rx;
        next_bus_pipe = {bus_pipe[BUS_WAKE_DELAY-2:0], bus_edge};
        next_receiver_enable = !test_mode; // R02
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            test_sync <= '0;
            // Follow the pin in reset; a fixed value would fake an edge after release
            wake_prev <= next_wake_prev;
            bus_prev <= 1'b1;
            bus_pipe <= '0;
            receiver_enable <= 1'b1;
        end
        else
        begin
            test_sync <= next_test_sync;
            wake_prev <= next_wake_prev;
            bus_prev <= next_bus_prev;
            bus_pipe <= next_bus_pipe;
            receiver_enable <= next_receiver_enable;
        end
    end

    // Only ever drives low or releases
    assign link.die_reset_oe = reset_oe; // R07
    assign link.die_irq_oe = irq_oe;
endmodule : sswr_die_end

//--- src/sswr_link_if.sv
/*
 * Link between the analog die supervisor and the controller: the shared
 * open-drain reset line, the open-drain interrupt line and the supply-on
 * acknowledge strobe. Assumes pull-ups, modelled by the wired level here.
 */
`timescale 1ns/100ps
interface sswr_link_if;
    logic die_reset_oe;
    logic ctrl_reset_oe;
    logic die_irq_oe;
    logic supply_on_ack_bit;
    logic reset_line;
    logic irq_line;

    // Open drain with pull-up: low when either side drives
    assign reset_line = ~(die_reset_oe | ctrl_reset_oe);
    assign irq_line = ~die_irq_oe;

    modport die (
        output die_reset_oe,
        output die_irq_oe,
        input reset_line,
        input supply_on_ack_bit
    );
    modport ctrl (
        output ctrl_reset_oe,
        output supply_on_ack_bit,
        input reset_line,
        input irq_line
    );
endinterface : sswr_link_if

//--- src/sswr_pkg.sv
/*
 * Constants shared by both ends of the supervision and reset/wake link:
 * timing counts at a 10 MHz clock, link widths and the supervisor states.
 * Assumes both ends run on the same 100 ns clock.
 */
package sswr_pkg;
    localparam int CLOCK_HZ = 10_000_000;
    // Startup acknowledge timeout, typical
    localparam int ACK_TIMEOUT_MS = 80;
    localparam int ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_MS * (CLOCK_HZ / 1000);
    // Reset hold after supply rise, typical, in microseconds
    localparam int RESET_HOLD_US = 1250;
    localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * (CLOCK_HZ / 1_000_000);
    // Bus wake reported this many cycles after the qualifying edge
    localparam int BUS_WAKE_DELAY = 2;
    localparam int COUNT_W = 24;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SSWR_HOLD = 2'b00,
        SSWR_WAIT_ACK = 2'b01,
        SSWR_NORMAL = 2'b10,
        SSWR_SLEEP = 2'b11
    } sswr_state_t;

    typedef enum logic [1:0] {
        SSWR_MODE_RUN = 2'b00,
        SSWR_MODE_STOP = 2'b01,
        SSWR_MODE_SLEEP = 2'b10
    } sswr_mode_t;
endpackage : sswr_pkg

//--- testbench/sswr_properties.sv
/* Link checker for the reset/wake supervisor.
   Assumes one clock and a bench that keeps reset sources quiet around resets. */
`timescale 1ns/100ps
module sswr_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic die_reset_oe,
    input wire logic ctrl_reset_oe,
    input wire logic die_irq_oe,
    input wire logic supply_on_ack_bit,
    input wire logic reset_line,
    input wire logic irq_line
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_die_pulls_low: assert property (die_reset_oe |-> !reset_line)
        else $error("die drive left reset high");
    a_ctrl_pulls_low: assert property (ctrl_reset_oe |-> !reset_line)
        else $error("controller drive left reset high");
    a_line_released: assert property (!(die_reset_oe || ctrl_reset_oe) |-> reset_line)
        else $error("reset line low without a driver");
    a_irq_follows: assert property (irq_line == !die_irq_oe)
        else $error("interrupt line disagrees with drive");
    a_irq_quiet_start: assert property ($fell(reset) |-> !die_irq_oe)
        else $error("interrupt driven right after reset");
    a_ack_one_cycle: assert property (supply_on_ack_bit |=> !supply_on_ack_bit)
        else $error("ack strobe longer than one cycle");
    a_hold_min: assert property ($fell(reset) |-> die_reset_oe [*5])
        else $error("reset hold too short");
    a_hold_max: assert property ($fell(reset) |-> ##[1:12] !die_reset_oe)
        else $error("reset hold never released");
endmodule : sswr_properties

//--- testbench/testbench.sv
/* Self-checking bench: die end and controller end joined by the link.
   Assumes short hold and timeout counts so the run stays brief. */
`timescale 1ns/100ps
module testbench;
    import sswr_pkg::*;
    localparam int HC = 5;
    localparam int TC = 20;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic tm = 1'h0, wk = 1'h0, brx = 1'h1, isrc = 1'h0, err = 1'h0;
    logic bm = 1'h1, wm = 1'h1, clr = 1'h0, ureq = 1'h0, uack = 1'h0;
    logic [1:0] mode = 2'h0;
    logic sleep, rxen, wfi, wfb, inr, irqp, ackd;
    logic [31:0] seed = 32'h42;
    int error_cnt = 0;
    int samples_checked = 0;
    sswr_link_if link_if();
    sswr_die_end #(.HOLD_CYCLES(HC), .TIMEOUT_CYCLES(TC)) sswr_die_end_inst (.clock(clock), .reset(reset),
        .link(link_if), .test_mode_pin(tm), .wake_input(wk), .bus_rx(brx), .internal_reset_src(isrc),
        .error_event(err), .mode_select(mode), .bus_wake_mask(bm), .wake_input_mask(wm), .irq_clear(clr),
        .sleep_active(sleep), .receiver_enable(rxen), .wake_flag_input(wfi), .wake_flag_bus(wfb));
    sswr_ctrl_end sswr_ctrl_end_inst (.clock(clock), .reset(reset), .link(link_if), .user_reset_request(ureq),
        .user_ack_write(uack), .in_reset(inr), .irq_pending(irqp), .ack_done(ackd));
    sswr_properties sswr_properties_inst (.clock(clock), .reset(reset), .die_reset_oe(link_if.die_reset_oe),
        .ctrl_reset_oe(link_if.ctrl_reset_oe), .die_irq_oe(link_if.die_irq_oe),
        .supply_on_ack_bit(link_if.supply_on_ack_bit), .reset_line(link_if.reset_line),
        .irq_line(link_if.irq_line));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    // Masked only in stop mode; run mode always interrupts
    function automatic logic exp_line(input logic [1:0] m, input logic k);
        return (m == SSWR_MODE_STOP) && !k;
    endfunction : exp_line

    task check(input string name, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    // Inputs change 10 ns after the edge
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask : cyc

    task pulse_clear;
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        cyc(1);
    endtask : pulse_clear

    task bus_pulse;
        brx = 1'h0;
        cyc(2);
        brx = 1'h1;
        cyc(4);
    endtask : bus_pulse

    task ack_write;
        uack = 1'h1;
        cyc(1);
        uack = 1'h0;
    endtask : ack_write

    task wrap_up;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        forever #50 clock = ~clock;
    end

    initial
    begin
        #(100 * 4000);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        cyc(6);
        reset = 1'h0;
        cyc(3);
        check("hold", link_if.reset_line, 1'h0);
        cyc(HC + 2);
        check("release", link_if.reset_line, 1'h1);
        cyc(TC + 6);
        check("timeout", sleep, 1'h1);
        check("sleep line", link_if.reset_line, 1'h0);
        wk = ~wk;
        cyc(3);
        check("sleep wake", sleep, 1'h0);
        check("wake hold", link_if.reset_line, 1'h0);
        cyc(HC + 4);
        ack_write();
        cyc(TC + 8);
        check("acked", sleep, 1'h0);
        check("ack done", ackd, 1'h1);
        pulse_clear();
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            mode = {1'h0, seed[0]};
            wm = seed[1];
            cyc(int'(seed[4:2]) + 1);
            wk = ~wk;
            cyc(2);
            check("wake irq", link_if.irq_line, exp_line(mode, wm));
            check("wake flag", wfi, 1'h1);
            cyc(3);
            check("pending", irqp, ~exp_line(mode, wm));
            pulse_clear();
        end
        mode = SSWR_MODE_RUN;
        bus_pulse();
        check("bus flag", wfb, 1'h1);
        pulse_clear();
        err = 1'h1;
        cyc(1);
        err = 1'h0;
        cyc(1);
        check("error irq", link_if.irq_line, 1'h0);
        pulse_clear();
        // Error and clear in one cycle: the set must win
        err = 1'h1;
        clr = 1'h1;
        cyc(1);
        err = 1'h0;
        clr = 1'h0;
        cyc(1);
        check("set wins", link_if.irq_line, 1'h0);
        pulse_clear();
        mode = SSWR_MODE_STOP;
        bm = 1'h0;
        bus_pulse();
        check("bus masked", link_if.irq_line, 1'h1);
        pulse_clear();
        bm = 1'h1;
        bus_pulse();
        check("bus unmasked", link_if.irq_line, 1'h0);
        pulse_clear();
        mode = SSWR_MODE_SLEEP;
        cyc(3);
        check("sleep entry", sleep, 1'h1);
        check("sleep reset", link_if.reset_line, 1'h0);
        // Stop-mode mask must not block a wake from sleep
        mode = SSWR_MODE_STOP;
        bm = 1'h0;
        bus_pulse();
        check("bus sleep wake", sleep, 1'h0);
        cyc(HC + 5);
        ack_write();
        cyc(3);
        check("reacked", ackd, 1'h1);
        mode = SSWR_MODE_RUN;
        bm = 1'h1;
        isrc = 1'h1;
        cyc(2);
        check("source low", link_if.reset_line, 1'h0);
        cyc(3);
        check("in reset", inr, 1'h1);
        isrc = 1'h0;
        ureq = 1'h1;
        cyc(2);
        check("ctrl low", link_if.reset_line, 1'h0);
        ureq = 1'h0;
        // Mid-run reset with the test pin up
        tm = 1'h1;
        reset = 1'h1;
        cyc(6);
        reset = 1'h0;
        cyc(HC + TC + 30);
        check("test no sleep", sleep, 1'h0);
        check("rx off", rxen, 1'h0);
        bus_pulse();
        check("bus off", wfb, 1'h0);
        tm = 1'h0;
        cyc(4);
        check("rx on", rxen, 1'h1);
        wrap_up();
    end
endmodule : testbench
